// *** common/trip_auto_reset_map.svh ***
`ifndef TRIP_AUTO_RESET_MAP_SVH
`define TRIP_AUTO_RESET_MAP_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL 5'h00
`define OFS_LIMIT 5'h04
`define OFS_DELAY 5'h08
`define OFS_ACTION 5'h0c
`define OFS_STATUS 5'h10

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define CTRL_RST_REQ_BIT 0
`define CTRL_HOLD_BIT 1
`define ACT_STOP_BIT 0
`define ACT_BRK_BIT 1
`define ACT_PHASE_BIT 2
`define ACT_THERM_BIT 3
`define LIMIT_RST 3'h0
`define LIMIT_MAX 3'h5
`define DELAY_RST 8'h0a
`define DELAY_MAX 8'hfa
`define ACTION_RST 4'h0

// ------------------------------------------------------------
// Timing, in a 100 ms tick
// ------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define TICK_NS 100000000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define QUIET_MIN 5
`define QUIET_TICKS 12'(`QUIET_MIN * 60 * 10)
`define LONG_DELAY_S 10
`define LONG_DELAY_TICKS 8'(`LONG_DELAY_S * 10)
`define BRK_TRIP_PCT 7'h64
`define BRK_RELEASE_PCT 7'h5f

// ------------------------------------------------------------
// Trip codes
// ------------------------------------------------------------
`define TC_UNDERVOLTAGE 8'h01
`define TC_INSTANT_AC_OC 8'h03
`define TC_BRAKING_OC 8'h04
`define TC_EXTERNAL 8'h06
`define TC_RES_THERMISTOR 8'h0a
`define TC_BRAKE_OVERLOAD 8'h13
`define TC_MOTOR_THERMISTOR 8'h18
`define TC_THERMISTOR_SHORT 8'h19
`define TC_DOUT_OVERLOAD 8'h1a
`define TC_INPUT2_LOOP 8'h1c
`define TC_INPUT3_LOOP 8'h1d
`define TC_SERIAL_LOSS 8'h1e
`define TC_STORED_DATA 8'h1f
`define TC_PHASE_LOSS 8'h20
`define TC_HW_FAULT_MIN 8'hc8

`endif

// *** common/trip_auto_reset_pkg.sv ***
package trip_auto_reset_pkg;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_STOP = 4'h2,
    ST_TRIP = 4'h4,
    ST_WAIT = 4'h8
  } ctl_state_t;

  // Whole state of the control block
  typedef struct packed {
    ctl_state_t state;
    logic waitreq;
    logic [31:0] rdata;
    logic rst_req;
    logic hold;
    logic [2:0] limit;
    logic [7:0] delay;
    logic [3:0] action;
    logic pin_s1;
    logic pin_s2;
    logic pin_d;
    logic [2:0] cnt;
    logic [7:0] last_code;
    logic have_last;
    logic [21:0] presc;
    logic [7:0] dly_cnt;
    logic [7:0] target;
    logic [11:0] quiet;
    logic drv_reset;
    logic man;
    logic trip_active;
    logic healthy;
    logic stop_req;
    logic brake_inhibit;
    logic no_auto;
    logic long_cls;
    logic auto_ok;
    logic [7:0] pend_code;
  } ctl_regs_t;

endpackage : trip_auto_reset_pkg

// *** rtl/trip_auto_reset_control.sv ***
// What this block does
// [RULE_01] Reset request bit rising from zero to one resets drive once.
// [RULE_02] Attempt limit takes 0 to 5; zero disables automatic reset.
// [RULE_03] Nonzero limit gives automatic reset after trips, up to limit.
// [RULE_04] Automatic reset follows trip after 0.0-25.0 s delay, default 1.0.
// [RULE_05] Overcurrent class waits at least 10 s before automatic reset.
// [RULE_06] Counter grows only on same code; different code zeroes it.
// [RULE_07] Counter at limit: same trip gets no automatic reset.
// [RULE_08] Five trip-free minutes clear the counter.
// [RULE_09] Undervoltage, external, stored data, hardware faults never auto-reset.
// [RULE_10] Manual reset zeroes the counter.
// [RULE_11] Hold flag clear: every trip drops drive healthy.
// [RULE_12] Hold flag set: healthy stays through trip with reset pending.
// [RULE_13] Trip-action field 0-15: stop, braking, phase loss, thermistor bits.
// [RULE_14] Non-important trips: thermistors, output overload, loops, serial loss.
// [RULE_15] Action bit 0 clear: non-important trip trips at once.
// [RULE_16] Action bit 0 set: stop motor first, except in regen mode.
// [RULE_17] Accumulator 100%: trip, or inhibit braking until below 95%.
// [RULE_18] Action bit 2 drops phase loss trip, smallest low-voltage frame.
// [RULE_19] Action bit 3 drops resistor thermistor trip on smallest frame.
// [RULE_20] Delays timed by a fixed tick, restarted at each trip.
`timescale 1ns/10ps
`include "trip_auto_reset_map.svh"

module trip_auto_reset_control #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic reset_terminal,
  input wire logic trip_req,
  input wire logic [7:0] trip_code,
  input wire logic regen_mode,
  input wire logic motor_stopped,
  input wire logic [6:0] brake_accum_pct,
  input wire logic phase_loss,
  input wire logic resistor_open,
  input wire logic frame_smallest,
  input wire logic supply_low_voltage,
  output logic drive_reset,
  output logic trip_active,
  output logic drive_healthy,
  output logic stop_request,
  output logic brake_inhibit,
  output logic [7:0] active_trip_code,
  output logic [2:0] reset_count
);

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  localparam trip_auto_reset_pkg::ctl_regs_t RST_VAL = '{
    state: trip_auto_reset_pkg::ST_IDLE,
    waitreq: 1'b1,
    healthy: 1'b1,
    limit: `LIMIT_RST,
    delay: `DELAY_RST,
    action: `ACTION_RST,
    default: '0
  };

  trip_auto_reset_pkg::ctl_regs_t st_r;
  trip_auto_reset_pkg::ctl_regs_t st_nxt;

  // Outputs straight from the state
  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = st_r.waitreq;
  assign drive_reset = st_r.drv_reset;
  assign trip_active = st_r.trip_active;
  assign drive_healthy = st_r.healthy;
  assign stop_request = st_r.stop_req;
  assign brake_inhibit = st_r.brake_inhibit;
  assign active_trip_code = st_r.pend_code;
  assign reset_count = st_r.cnt;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    logic req;
    logic tick;
    logic manual;
    logic brk_over;
    logic brk_trip;
    logic ph_trip;
    logic th_trip;
    logic hit;
    logic [7:0] code;
    logic [2:0] c;
    logic na;
    logic lng;
    logic minor;
    logic ok;
    logic go_trip;
    req = 1'b0;
    tick = 1'b0;
    manual = 1'b0;
    brk_over = 1'b0;
    brk_trip = 1'b0;
    ph_trip = 1'b0;
    th_trip = 1'b0;
    hit = 1'b0;
    code = 8'h00;
    c = 3'h0;
    na = 1'b0;
    lng = 1'b0;
    minor = 1'b0;
    ok = 1'b0;
    go_trip = 1'b0;
    st_nxt = st_r;
    st_nxt.drv_reset = 1'b0;
    st_nxt.man = 1'b0;

    // Reset terminal synchroniser and edge memory
    st_nxt.pin_s1 = reset_terminal;
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.pin_d = st_r.pin_s2;

    // Fixed 100 ms tick
    tick = (st_r.presc == 22'(TICK_CYCLES - 1));
    st_nxt.presc = tick ? 22'h000000 : st_r.presc + 22'h000001; // see [RULE_20]

    // Bus slave: one wait cycle, then answer
    req = (avs_read | avs_write) & st_r.waitreq;
    st_nxt.waitreq = ~req;
    if (req && avs_read)
    begin
      unique case (avs_address & 5'h1c)
        `OFS_CTRL: st_nxt.rdata = {30'h0, st_r.hold, st_r.rst_req};
        `OFS_LIMIT: st_nxt.rdata = {29'h0, st_r.limit};
        `OFS_DELAY: st_nxt.rdata = {24'h0, st_r.delay};
        `OFS_ACTION: st_nxt.rdata = {28'h0, st_r.action};
        `OFS_STATUS: st_nxt.rdata = {8'h0, st_r.pend_code, 7'h00, st_r.state,
                                     st_r.trip_active, st_r.healthy, st_r.cnt};
        default: st_nxt.rdata = 32'h0;
      endcase
    end
    if (req && avs_write && avs_byteenable[0])
    begin
      unique case (avs_address & 5'h1c)
        `OFS_CTRL:
        begin
          st_nxt.rst_req = avs_writedata[`CTRL_RST_REQ_BIT];
          st_nxt.hold = avs_writedata[`CTRL_HOLD_BIT];
        end
        `OFS_LIMIT: // see [RULE_02]
          st_nxt.limit = (avs_writedata[7:0] > 8'(`LIMIT_MAX)) ? `LIMIT_MAX
                         : avs_writedata[2:0];
        `OFS_DELAY: // see [RULE_04]
          st_nxt.delay = (avs_writedata[7:0] > `DELAY_MAX) ? `DELAY_MAX
                         : avs_writedata[7:0];
        `OFS_ACTION: st_nxt.action = avs_writedata[3:0]; // see [RULE_13]
        default: st_nxt.action = st_r.action;
      endcase
    end

    // Manual reset: bit edge or terminal edge
    manual = (st_nxt.rst_req & ~st_r.rst_req) | (st_r.pin_s2 & ~st_r.pin_d); // see [RULE_01]

    // Braking accumulator supervision
    brk_over = (brake_accum_pct >= `BRK_TRIP_PCT);
    brk_trip = brk_over & ~st_r.action[`ACT_BRK_BIT]; // see [RULE_17]
    if (brk_over && st_r.action[`ACT_BRK_BIT])
      st_nxt.brake_inhibit = 1'b1; // see [RULE_17]
    else if (brake_accum_pct < `BRK_RELEASE_PCT)
      st_nxt.brake_inhibit = 1'b0;

    // Frame-dependent trip suppression
    ph_trip = phase_loss & ~(st_r.action[`ACT_PHASE_BIT] & frame_smallest
                             & supply_low_voltage); // see [RULE_18]
    th_trip = resistor_open & ~(st_r.action[`ACT_THERM_BIT]
                                & frame_smallest); // see [RULE_19]

    // Trip source priority
    hit = trip_req | brk_trip | ph_trip | th_trip;
    if (trip_req)
      code = trip_code;
    else if (brk_trip)
      code = `TC_BRAKE_OVERLOAD;
    else if (ph_trip)
      code = `TC_PHASE_LOSS;
    else
      code = `TC_RES_THERMISTOR;

    // Trip classes
    na = (code == `TC_UNDERVOLTAGE) | (code == `TC_EXTERNAL)
         | (code == `TC_STORED_DATA) | (code >= `TC_HW_FAULT_MIN); // see [RULE_09]
    lng = (code == `TC_INSTANT_AC_OC) | (code == `TC_BRAKING_OC); // see [RULE_05]
    minor = (code == `TC_MOTOR_THERMISTOR) | (code == `TC_THERMISTOR_SHORT)
            | (code == `TC_DOUT_OVERLOAD) | (code == `TC_INPUT2_LOOP)
            | (code == `TC_INPUT3_LOOP) | (code == `TC_SERIAL_LOSS); // see [RULE_14]

    // Trip-free interval
    if (tick && st_r.quiet != `QUIET_TICKS)
      st_nxt.quiet = st_r.quiet + 12'h001;
    if (tick && st_r.quiet == `QUIET_TICKS - 12'h001)
      st_nxt.cnt = 3'h0; // see [RULE_08]

    // Sequencer
    unique case (st_r.state)
      trip_auto_reset_pkg::ST_IDLE:
      begin
        if (hit)
        begin
          c = (st_r.have_last && code == st_r.last_code) ? st_r.cnt : 3'h0; // see [RULE_06]
          ok = (st_r.limit != 3'h0) & ~na & (c < st_r.limit); // see [RULE_02] [RULE_07]
          st_nxt.cnt = c;
          st_nxt.last_code = code;
          st_nxt.have_last = 1'b1;
          st_nxt.pend_code = code;
          st_nxt.no_auto = na;
          st_nxt.long_cls = lng;
          st_nxt.auto_ok = ok;
          st_nxt.quiet = 12'h000; // see [RULE_20]
          st_nxt.presc = 22'h000000; // see [RULE_20]
          if (minor && st_r.action[`ACT_STOP_BIT] && !regen_mode)
          begin
            st_nxt.state = trip_auto_reset_pkg::ST_STOP; // see [RULE_16]
            st_nxt.stop_req = 1'b1;
          end
          else
            go_trip = 1'b1; // see [RULE_15]
        end
      end
      trip_auto_reset_pkg::ST_STOP:
      begin
        if (motor_stopped || regen_mode)
        begin
          ok = st_r.auto_ok;
          lng = st_r.long_cls;
          st_nxt.stop_req = 1'b0;
          go_trip = 1'b1; // see [RULE_16]
        end
      end
      trip_auto_reset_pkg::ST_WAIT:
      begin
        if (st_r.dly_cnt >= st_r.target)
        begin
          st_nxt.drv_reset = 1'b1; // see [RULE_03]
          st_nxt.cnt = st_r.cnt + 3'h1;
          st_nxt.trip_active = 1'b0;
          st_nxt.healthy = 1'b1;
          st_nxt.state = trip_auto_reset_pkg::ST_IDLE;
        end
        else if (tick)
          st_nxt.dly_cnt = st_r.dly_cnt + 8'h01; // see [RULE_04]
      end
      trip_auto_reset_pkg::ST_TRIP:
        st_nxt.state = trip_auto_reset_pkg::ST_TRIP;
    endcase

    // Entry into the tripped state
    if (go_trip)
    begin
      st_nxt.trip_active = 1'b1;
      st_nxt.healthy = st_r.hold & ok; // see [RULE_11] [RULE_12]
      st_nxt.dly_cnt = 8'h00;
      st_nxt.target = (lng && st_r.delay < `LONG_DELAY_TICKS) ? `LONG_DELAY_TICKS
                      : st_r.delay; // see [RULE_05]
      st_nxt.state = ok ? trip_auto_reset_pkg::ST_WAIT
                     : trip_auto_reset_pkg::ST_TRIP; // see [RULE_03]
    end

    // Manual reset overrides state, counter, healthy, trip active and stop request
    if (manual)
    begin
      st_nxt.drv_reset = 1'b1; // see [RULE_01]
      st_nxt.man = 1'b1;
      st_nxt.cnt = 3'h0; // see [RULE_10]
      st_nxt.trip_active = 1'b0;
      st_nxt.healthy = 1'b1;
      st_nxt.stop_req = 1'b0;
      st_nxt.state = trip_auto_reset_pkg::ST_IDLE;
    end
  end

  // Register the whole state
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      st_r <= RST_VAL;
    else
      st_r <= st_nxt;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  reset_edge_a: assert property ($rose(st_r.rst_req) |-> st_r.drv_reset) // see [RULE_01]
    else $error("reset bit edge gave no drive reset");
  reset_once_a: assert property ( // see [RULE_01]
    st_r.rst_req && $past(st_r.rst_req) && $past(st_r.state) == trip_auto_reset_pkg::ST_IDLE
    && !$past(st_r.pin_s2 && !st_r.pin_d) |-> !st_r.drv_reset)
    else $error("held reset bit repeated the reset");
  limit_range_a: assert property (st_r.limit <= `LIMIT_MAX) // see [RULE_02]
    else $error("attempt limit above five");
  wait_allowed_a: assert property ( // see [RULE_07]
    st_r.state == trip_auto_reset_pkg::ST_WAIT && $past(st_r.state) != st_r.state
    |-> st_r.limit != 3'h0 && st_r.cnt < st_r.limit && !st_r.no_auto)
    else $error("auto reset armed when not allowed");
  no_auto_class_a: assert property ( // see [RULE_09]
    st_r.no_auto && st_r.trip_active |-> st_r.state != trip_auto_reset_pkg::ST_WAIT)
    else $error("auto reset armed for excluded trip");
  long_delay_a: assert property ( // see [RULE_05]
    st_r.state == trip_auto_reset_pkg::ST_WAIT && st_r.long_cls
    |-> st_r.target >= `LONG_DELAY_TICKS)
    else $error("overcurrent delay below ten seconds");
  auto_fire_a: assert property ( // see [RULE_04]
    $past(st_r.state) == trip_auto_reset_pkg::ST_WAIT && st_r.drv_reset && !st_r.man
    |-> $past(st_r.dly_cnt) >= $past(st_r.target) && st_r.cnt == $past(st_r.cnt) + 3'h1)
    else $error("auto reset before its delay");
  manual_clear_a: assert property (st_r.man |-> st_r.cnt == 3'h0 && st_r.healthy) // see [RULE_10]
    else $error("manual reset left counter set");
  healthy_drop_a: assert property ( // see [RULE_11]
    $rose(st_r.trip_active) && !st_r.hold |-> !st_r.healthy)
    else $error("healthy kept with hold flag clear");
  healthy_hold_a: assert property ( // see [RULE_12]
    $rose(st_r.trip_active) && st_r.hold && st_r.state == trip_auto_reset_pkg::ST_WAIT
    |-> st_r.healthy)
    else $error("healthy dropped with reset pending");
  stop_first_a: assert property ( // see [RULE_16]
    $rose(st_r.stop_req) |-> st_r.action[`ACT_STOP_BIT] && !$past(regen_mode)
    && !st_r.trip_active)
    else $error("stop before trip without its bit");

  // Counter, quiet interval, terminal, stop-first and braking checks
  same_code_a: assert property ( // see [RULE_06]
    $past(st_r.state) == trip_auto_reset_pkg::ST_IDLE
    && st_r.state != trip_auto_reset_pkg::ST_IDLE
    |-> st_r.cnt == (($past(st_r.have_last) && $past(st_r.last_code) == st_r.pend_code)
    ? $past(st_r.cnt) : 3'h0))
    else $error("reset count not kept on same trip code");
  quiet_clear_a: assert property ( // see [RULE_08]
    st_r.quiet == `QUIET_TICKS && $past(st_r.quiet) != `QUIET_TICKS |-> st_r.cnt == 3'h0)
    else $error("count kept after trip-free interval");
  term_reset_a: assert property ( // see [RULE_01]
    st_r.pin_s2 && !st_r.pin_d |=> st_r.drv_reset && st_r.man)
    else $error("reset terminal edge gave no drive reset");
  immediate_trip_a: assert property ( // see [RULE_15]
    $past(st_r.state) == trip_auto_reset_pkg::ST_IDLE && !$past(st_r.action[`ACT_STOP_BIT])
    && st_r.state != trip_auto_reset_pkg::ST_IDLE |-> st_r.trip_active && !st_r.stop_req)
    else $error("trip delayed with stop bit clear");
  minor_stop_a: assert property ( // see [RULE_14]
    $rose(st_r.stop_req) |-> st_r.pend_code inside {`TC_MOTOR_THERMISTOR, `TC_THERMISTOR_SHORT,
    `TC_DOUT_OVERLOAD, `TC_INPUT2_LOOP, `TC_INPUT3_LOOP, `TC_SERIAL_LOSS})
    else $error("stop before trip on important trip");
  brake_set_a: assert property ( // see [RULE_17]
    brake_accum_pct >= `BRK_TRIP_PCT && st_r.action[`ACT_BRK_BIT] |=> st_r.brake_inhibit)
    else $error("braking not inhibited at full accumulator");
  brake_free_a: assert property ( // see [RULE_17]
    brake_accum_pct < `BRK_RELEASE_PCT |=> !st_r.brake_inhibit)
    else $error("braking inhibit held below release level");

  auto_reset_c: cover property (
    st_r.state == trip_auto_reset_pkg::ST_WAIT ##1 st_r.drv_reset && !st_r.man);
  stop_path_c: cover property (
    st_r.state == trip_auto_reset_pkg::ST_STOP ##1 st_r.trip_active);
  manual_c: cover property (st_r.man && $past(st_r.trip_active));
  limit_hit_c: cover property (
    $rose(st_r.trip_active) && st_r.state == trip_auto_reset_pkg::ST_TRIP && st_r.cnt != 3'h0);
  quiet_clear_c: cover property (
    st_r.quiet == `QUIET_TICKS && $past(st_r.quiet) != `QUIET_TICKS);

endmodule : trip_auto_reset_control

// *** sim/trip_auto_reset_control_bench.sv ***
`timescale 1ns/10ps
`include "trip_auto_reset_map.svh"

module trip_auto_reset_control_bench;
  // ------------------------------------------------------------
  // Signals and stimulus tables
  // ------------------------------------------------------------
  localparam int TK = 4;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic reset_terminal = 1'b0;
  logic trip_req = 1'b0;
  logic [7:0] trip_code = 8'h00;
  logic regen_mode = 1'b0;
  logic motor_stopped = 1'b0;
  logic [6:0] brake_accum_pct = 7'h00;
  logic phase_loss = 1'b0;
  logic resistor_open = 1'b0;
  logic frame_smallest = 1'b1;
  logic supply_low_voltage = 1'b1;
  logic drive_reset, trip_active, drive_healthy, stop_request, brake_inhibit;
  logic [7:0] active_trip_code;
  logic [2:0] reset_count;
  logic [31:0] rd;
  logic [31:0] rv [5] = '{32'(`LIMIT_RST), 32'(`DELAY_RST), 32'(`ACTION_RST), 32'h28, 32'h0};
  logic [7:0] niv [6] = '{`TC_MOTOR_THERMISTOR, `TC_THERMISTOR_SHORT, `TC_DOUT_OVERLOAD,
    `TC_INPUT2_LOOP, `TC_INPUT3_LOOP, `TC_SERIAL_LOSS};
  logic [7:0] nrc [4] = '{`TC_UNDERVOLTAGE, `TC_EXTERNAL, `TC_STORED_DATA, `TC_HW_FAULT_MIN};
  logic [3:0] bact [4] = '{4'h2, 4'h2, 4'h2, 4'h0};
  logic [6:0] bpct [4] = '{`BRK_TRIP_PCT, `BRK_RELEASE_PCT, 7'h5e, `BRK_TRIP_PCT};
  logic [7:0] codes [6];
  logic [7:0] a, b, last;
  logic hold = 1'b0;
  logic h;
  bit ok;
  int fails = 0;
  int check_count = 0;
  int pulses = 0;
  int cycles = 0;
  int n, p, ec;

  trip_auto_reset_control #(.TICK_CYCLES(TK)) dut (
    .clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .reset_terminal(reset_terminal), .trip_req(trip_req), .trip_code(trip_code),
    .regen_mode(regen_mode), .motor_stopped(motor_stopped), .brake_accum_pct(brake_accum_pct),
    .phase_loss(phase_loss), .resistor_open(resistor_open), .frame_smallest(frame_smallest),
    .supply_low_voltage(supply_low_voltage), .drive_reset(drive_reset), .trip_active(trip_active),
    .drive_healthy(drive_healthy), .stop_request(stop_request), .brake_inhibit(brake_inhibit),
    .active_trip_code(active_trip_code), .reset_count(reset_count));

  // Clock
  initial
  begin
    forever #20 clk = ~clk;
  end

  // Reset pulse count and hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (drive_reset === 1'b1)
      pulses++;
    if (cycles == 40000)
    begin
      fails++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One Avalon cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] d);
    @(posedge clk);
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic ctrl(input logic bit0);
    bus(1'b1, `OFS_CTRL, {30'h0, hold, bit0});
  endtask : ctrl

  // Software manual reset by a fresh rising edge
  task automatic mrst();
    ctrl(1'b0);
    ctrl(1'b1);
  endtask : mrst

  task automatic fire(input logic [7:0] c);
    @(posedge clk);
    trip_req <= 1'b1;
    trip_code <= c;
    @(posedge clk);
    trip_req <= 1'b0;
  endtask : fire

  // Trip, note health at trip, count cycles to reset (600 means none)
  task automatic run_trip(input logic [7:0] c);
    fire(c);
    n = 0;
    do @(negedge clk); while (trip_active !== 1'b1 && ++n < 10);
    h = drive_healthy;
    n = 0;
    while (drive_reset !== 1'b1 && n < 600)
    begin
      @(negedge clk);
      n++;
    end
  endtask : run_trip

  task automatic wrap_up();
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h25c6b8df));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    // Reset values, unmapped place, clamping
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, 5'(i * 4 + 4), 32'h0);
      chk("reset_value", rd, rv[i]);
    end
    bus(1'b1, `OFS_LIMIT, 32'h7);
    bus(1'b0, `OFS_LIMIT, 32'h0);
    chk("limit_clamp", rd, 32'(`LIMIT_MAX));
    bus(1'b1, `OFS_DELAY, 32'hff);
    bus(1'b0, `OFS_DELAY, 32'h0);
    chk("delay_clamp", rd, 32'(`DELAY_MAX));
    bus(1'b1, `OFS_ACTION, 32'hf);
    bus(1'b0, `OFS_ACTION, 32'h0);
    chk("action", rd, 32'hf);
    bus(1'b1, `OFS_ACTION, 32'h0);
    // Edge-only software reset
    p = pulses;
    ctrl(1'b1);
    ctrl(1'b1);
    repeat (3) @(posedge clk);
    chk("edge_reset", pulses, p + 1);
    // Repeated trips against a model of the counter; last one meets the limit
    hold = 1'b1;
    ctrl(1'b1);
    bus(1'b1, `OFS_LIMIT, 32'h3);
    bus(1'b1, `OFS_DELAY, 32'h0);
    a = 8'h40 + 8'($urandom % 16);
    b = a + 8'h10;
    codes = '{a, a, b, b, b, b};
    ec = 0;
    last = 8'h00;
    foreach (codes[i])
    begin
      if (codes[i] != last)
        ec = 0;
      last = codes[i];
      ok = ec < 3;
      p = pulses;
      run_trip(codes[i]);
      repeat (2) @(posedge clk);
      if (ok)
        ec++;
      chk("healthy_hold", h, ok);
      chk("auto_reset", pulses, p + ok);
      chk("count", reset_count, ec);
    end
    chk("at_limit", trip_active, 1'b1);
    reset_terminal <= 1'b1;
    repeat (8) @(posedge clk);
    reset_terminal <= 1'b0;
    chk("term_clear", trip_active, 1'b0);
    chk("term_count", reset_count, 3'h0);
    // Quiet interval clears the count
    hold = 1'b0;
    ctrl(1'b1);
    run_trip(a);
    chk("healthy_drop", h, 1'b0);
    repeat (11800) @(posedge clk);
    chk("quiet_early", reset_count, 3'h1);
    repeat (400) @(posedge clk);
    chk("quiet_clear", reset_count, 3'h0);
    // Programmed and enforced delays
    bus(1'b1, `OFS_DELAY, 32'h3);
    run_trip(b);
    chk("delay", n >= 3 * TK && n <= 4 * TK + 3, 1'b1);
    bus(1'b1, `OFS_DELAY, 32'h0);
    run_trip(`TC_INSTANT_AC_OC);
    chk("long_delay", n >= 100 * TK && n <= 101 * TK + 3, 1'b1);
    run_trip(`TC_BRAKING_OC);
    chk("long_delay", n >= 100 * TK && n <= 101 * TK + 3, 1'b1);
    // Classes that never reset themselves
    nrc[3] = `TC_HW_FAULT_MIN + 8'($urandom % 32);
    foreach (nrc[i])
    begin
      run_trip(nrc[i]);
      chk("no_auto", n, 600);
      mrst();
    end
    bus(1'b1, `OFS_LIMIT, 32'h0);
    run_trip(a);
    chk("limit_zero", n, 600);
    mrst();
    // Stop first on minor trips, not on others
    bus(1'b1, `OFS_ACTION, 32'h1);
    for (int i = 0; i < 7; i++)
    begin
      fire(i < 6 ? niv[i] : a);
      @(negedge clk);
      chk("stop_req", stop_request, i < 6);
      @(posedge clk);
      motor_stopped <= 1'b1;
      repeat (4) @(posedge clk);
      motor_stopped <= 1'b0;
      chk("tripped", trip_active, 1'b1);
      mrst();
    end
    regen_mode <= 1'b1;
    for (int j = 0; j < 2; j++)
    begin
      fire(niv[$urandom % 6]);
      @(negedge clk);
      chk("immediate", trip_active, 1'b1);
      chk("no_stop", stop_request, 1'b0);
      @(posedge clk);
      regen_mode <= 1'b0;
      mrst();
      bus(1'b1, `OFS_ACTION, 32'h0);
    end
    // Braking accumulator thresholds
    foreach (bact[i])
    begin
      bus(1'b1, `OFS_ACTION, 32'(bact[i]));
      brake_accum_pct <= bpct[i];
      repeat (4) @(posedge clk);
      chk("inhibit", brake_inhibit, i < 2);
      chk("brk_trip", trip_active, i == 3);
    end
    brake_accum_pct <= 7'h00;
    mrst();
    // Phase loss and resistor thermistor suppression
    for (int k = 2; k < 4; k++)
    begin
      // Suppression bit first, so the pin never meets an unset bit
      bus(1'b1, `OFS_ACTION, 32'(1 << k));
      phase_loss <= (k == 2);
      resistor_open <= (k == 3);
      repeat (4) @(posedge clk);
      chk("suppressed", trip_active, 1'b0);
      bus(1'b1, `OFS_ACTION, 32'h0);
      repeat (4) @(posedge clk);
      chk("pin_trip", active_trip_code, k == 2 ? `TC_PHASE_LOSS : `TC_RES_THERMISTOR);
      phase_loss <= 1'b0;
      resistor_open <= 1'b0;
      mrst();
      // Bit set, but not the frame or supply that allows suppression
      bus(1'b1, `OFS_ACTION, 32'(1 << k));
      frame_smallest <= (k == 2);
      supply_low_voltage <= (k == 3);
      phase_loss <= (k == 2);
      resistor_open <= (k == 3);
      repeat (4) @(posedge clk);
      chk("other_frame", trip_active, 1'b1);
      frame_smallest <= 1'b1;
      supply_low_voltage <= 1'b1;
      phase_loss <= 1'b0;
      resistor_open <= 1'b0;
      mrst();
    end
    wrap_up();
  end
endmodule : trip_auto_reset_control_bench
